// File: verilog/spi_quirk_pkg.sv
// Constants, register map and types of the SPI unit with start-up quirks
// Behaviour
// RULE_01: Serial clock rests low for polarity 0 and high for polarity 1.
// RULE_02: Fault only for a phase-1 slave whose clock is off idle at reset release.
// RULE_03: A-type fault: no byte received, no receive flag, first output bit dropped.
// RULE_04: B-type fault: reception fine, first output byte sent twice.
// RULE_05: External master parks the clock at idle before the reset release.
// RULE_06: A-type: two transmit flags without receive flag pulse soft reset, ask resend.
// RULE_07: 4-pin master: role 0 makes enable an input, role 1 drives it.
// RULE_08: Enable-input mode: a byte written while enable inactive may go wrong.
// RULE_09: Enable-input mode: transmit buffer written only while enable is active.
// RULE_10: Transfer aborted by enable going inactive is reloaded and resent later.
// RULE_11: While soft reset is held, clock edges are ignored and counting stays idle.
package spi_quirk_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TXBUF  = 8'h04;
  localparam logic [7:0] ADDR_RXBUF  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_MASK   = 8'h10;
  localparam logic [7:0] ADDR_STATE  = 8'h14;

  // ----------------------------------------------------------------
  // control_word_zero fields
  // ----------------------------------------------------------------
  localparam int CTL_SWRST   = 0;
  localparam int CTL_CPHA    = 1;
  localparam int CTL_CPOL    = 2;
  localparam int CTL_MASTER  = 3;
  localparam int CTL_FOURPIN = 4;
  localparam int CTL_STEROLE = 5;
  localparam int CTL_BTYPE   = 6;
  localparam int CTL_AUTOREC = 7;
  localparam int CTL_DIV_LSB = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0301;

  // ----------------------------------------------------------------
  // Status, mask and state fields
  // ----------------------------------------------------------------
  localparam int ST_RX      = 0;
  localparam int ST_TX      = 1;
  localparam int ST_FAULT   = 2;
  localparam int ST_ABORT   = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_RESEND  = 5;
  localparam int ST_W       = 6;
  localparam logic [ST_W-1:0] MASK_RESET = 6'h00;
  localparam logic [7:0] IDLE_FILL = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] RESEND_TX_COUNT = 2'h2;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_RUN  = 2'b01,
    M_HOLD = 2'b10
  } mstate_t;

  typedef enum logic [1:0] {
    R_IDLE = 2'b00,
    R_SET  = 2'b01,
    R_CLR  = 2'b10
  } rstate_t;

endpackage

// File: verilog/spi_shift_if.sv
// Carrier between the control logic and the byte shifter
`timescale 1ns/1ps
interface spi_shift_if;
  logic       clear;
  logic       load;
  logic [7:0] load_data;
  logic       shift;
  logic       sample;
  logic       rx_bit;
  logic       out_bit;
  logic       byte_done;
  logic [7:0] rx_byte;
  logic [3:0] count;

  modport ctrl (output clear, load, load_data, shift, sample, rx_bit,
                input  out_bit, byte_done, rx_byte, count);
  modport eng  (input  clear, load, load_data, shift, sample, rx_bit,
                output out_bit, byte_done, rx_byte, count);
endinterface

// File: verilog/spi_byte_shifter.sv
// Eight-bit shift engine: one register out, one in, shared bit count
`timescale 1ns/1ps
module spi_byte_shifter
  import spi_quirk_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Control side
  spi_shift_if.eng sif
);

  logic [7:0] tx_sh_r;
  logic [7:0] rx_sh_r;
  logic [3:0] cnt_r;
  logic       done_r;

  assign sif.out_bit   = tx_sh_r[7];
  assign sif.rx_byte   = rx_sh_r;
  assign sif.count     = cnt_r;
  assign sif.byte_done = done_r;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_sh_r <= 8'h00;
      cnt_r   <= BYTE_BITS;
    end
    else if (sif.clear)
    begin
      tx_sh_r <= 8'h00;
      cnt_r   <= BYTE_BITS;
    end
    else if (sif.load)
    begin
      tx_sh_r <= sif.load_data;
      cnt_r   <= 4'h0;
    end
    else
    begin
      if (sif.shift)
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      if (sif.sample && cnt_r != BYTE_BITS)
        cnt_r <= cnt_r + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_sh_r <= 8'h00;
      done_r  <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (!sif.clear && !sif.load && sif.sample && cnt_r != BYTE_BITS)
      begin
        rx_sh_r <= {rx_sh_r[6:0], sif.rx_bit};
        done_r  <= (cnt_r == BYTE_BITS - 4'h1);
      end
    end
  end

endmodule

// File: verilog/spi_quirk_unit.sv
// SPI unit with APB registers, start-up phase fault and enable-pin guard
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module spi_quirk_unit
  import spi_quirk_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Serial clock pin
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe,
  // Controller-out data pin
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  // Peripheral-out data pin
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  // select_enable_line, active low
  input  wire logic        ste_n_in,
  output logic             ste_n_out,
  output logic             ste_oe
);

  spi_shift_if sif ();

  spi_byte_shifter u_shift (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .sif     (sif)
  );

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  logic [15:0]     ctrl_r;
  logic [7:0]      txbuf_r;
  logic [7:0]      rxbuf_r;
  logic [7:0]      last_byte_r;
  logic            tx_full_r;
  logic            rx_full_r;
  logic [ST_W-1:0] status_r;
  logic [ST_W-1:0] mask_r;
  logic            fault_r;
  logic            dup_pend_r;
  logic            swrst_d_r;
  logic [1:0]      tx_since_rx_r;
  mstate_t         mstate_r;
  rstate_t         rstate_r;
  logic [7:0]      div_cnt_r;
  logic            sclk_r;
  logic [3:0]      sync_a_r;
  logic [3:0]      sync_b_r;
  logic            sclk_prev_r;

  logic swrst, cpha, cpol, master, fourpin, ste_role, btype, autorec;
  assign swrst    = ctrl_r[CTL_SWRST];
  assign cpha     = ctrl_r[CTL_CPHA];
  assign cpol     = ctrl_r[CTL_CPOL];
  assign master   = ctrl_r[CTL_MASTER];
  assign fourpin  = ctrl_r[CTL_FOURPIN];
  assign ste_role = ctrl_r[CTL_STEROLE];
  assign btype    = ctrl_r[CTL_BTYPE];
  assign autorec  = ctrl_r[CTL_AUTOREC];

  logic sclk_s, mosi_s, miso_s, ste_n_s;
  assign {ste_n_s, miso_s, mosi_s, sclk_s} = sync_b_r;

  logic setup, acc, wr, rd;
  assign setup = psel && !penable;
  assign acc   = psel && penable && pready;
  assign wr    = acc && pwrite;
  assign rd    = acc && !pwrite;

  logic guard_mode, ste_active;
  assign guard_mode = master && fourpin && !ste_role;
  assign ste_active = !ste_n_s;

  // ----------------------------------------------------------------
  // Strobes from the serial clock
  // ----------------------------------------------------------------
  logic div_tick, lead_p, trail_p, sample_p, shift_p, clk_idle;
  assign div_tick = (div_cnt_r == ctrl_r[CTL_DIV_LSB +: 8]);
  always_comb
  begin
    lead_p  = 1'b0;
    trail_p = 1'b0;
    if (swrst)                                              // RULE_11
    begin
      lead_p  = 1'b0;
      trail_p = 1'b0;
    end
    else if (master)
    begin
      lead_p  = (mstate_r == M_RUN) && div_tick && (sclk_r == cpol);
      trail_p = (mstate_r == M_RUN) && div_tick && (sclk_r != cpol);
    end
    else
    begin
      lead_p  = (sclk_s != sclk_prev_r) && (sclk_prev_r == cpol); // RULE_01
      trail_p = (sclk_s != sclk_prev_r) && (sclk_prev_r != cpol); // RULE_01
    end
  end
  assign sample_p = cpha ? trail_p : lead_p;
  assign shift_p  = cpha ? lead_p  : trail_p;
  assign clk_idle = master ? (sclk_r == cpol) : (sclk_s == cpol);

  // ----------------------------------------------------------------
  // Loading the shifter
  // ----------------------------------------------------------------
  logic at_end, abort_p, load_p, consume_p, drop_a, rx_blocked;
  logic [7:0] load_byte;
  assign at_end     = (sif.count == BYTE_BITS);
  assign drop_a     = fault_r && !btype;                     // RULE_03
  assign rx_blocked = fault_r && !btype;                     // RULE_03
  assign abort_p    = guard_mode && (mstate_r == M_RUN)
                      && !ste_active;                        // RULE_10
  always_comb
  begin
    load_p    = 1'b0;
    consume_p = 1'b0;
    load_byte = txbuf_r;
    if (swrst)
    begin
      load_p = 1'b0;
    end
    else if (abort_p)
    begin
      load_p    = 1'b1;
      load_byte = last_byte_r;                               // RULE_10
    end
    else if (at_end && (shift_p || clk_idle))
    begin
      if (dup_pend_r && tx_full_r)
      begin
        load_p    = 1'b1;
        load_byte = txbuf_r;                                 // RULE_04
      end
      else if (tx_full_r)
      begin
        load_p    = 1'b1;
        consume_p = 1'b1;
      end
      else if (shift_p && !master)
      begin
        load_p    = 1'b1;
        load_byte = IDLE_FILL;
      end
    end
  end

  assign sif.clear     = swrst;                              // RULE_11
  assign sif.load      = load_p;
  assign sif.load_data = load_byte;
  assign sif.sample    = sample_p;
  assign sif.rx_bit    = master ? miso_s : mosi_s;
  assign sif.shift     = shift_p && !at_end
                         && !((sif.count == 4'h0) && cpha && !drop_a); // RULE_03

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync_a_r    <= 4'h8;
      sync_b_r    <= 4'h8;
      sclk_prev_r <= 1'b0;
    end
    else
    begin
      sync_a_r    <= {ste_n_in, miso_in, mosi_in, sclk_in};
      sync_b_r    <= sync_a_r;
      sclk_prev_r <= sync_b_r[0];
    end
  end

  // ----------------------------------------------------------------
  // Control word, with the automatic reset pulse
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ctrl_r <= CTRL_RESET;
    else if (rstate_r == R_SET)
      ctrl_r[CTL_SWRST] <= 1'b1;                             // RULE_06
    else if (rstate_r == R_CLR)
      ctrl_r[CTL_SWRST] <= 1'b0;                             // RULE_06
    else if (wr && paddr == ADDR_CTRL)
      ctrl_r <= pwdata[15:0];
  end

  // Recovery only helps when the master later parks the clock at idle
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstate_r      <= R_IDLE;
      tx_since_rx_r <= 2'h0;
    end
    else
    begin
      case (rstate_r)
        R_IDLE:
        begin
          if (swrst || (sif.byte_done && !rx_blocked))
            tx_since_rx_r <= 2'h0;
          else if (consume_p)
            tx_since_rx_r <= tx_since_rx_r + 2'h1;
          if (autorec && !btype && !master
              && tx_since_rx_r == RESEND_TX_COUNT)           // RULE_06
            rstate_r <= R_SET;
        end
        R_SET:   rstate_r <= R_CLR;
        R_CLR:
        begin
          rstate_r      <= R_IDLE;
          tx_since_rx_r <= 2'h0;
        end
        default: rstate_r <= R_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Start-up fault capture
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      swrst_d_r  <= 1'b1;
      fault_r    <= 1'b0;
      dup_pend_r <= 1'b0;
    end
    else
    begin
      swrst_d_r <= swrst;
      if (swrst)
      begin
        fault_r    <= 1'b0;
        dup_pend_r <= 1'b0;
      end
      else if (swrst_d_r)
      begin
        fault_r    <= !master && cpha && (sclk_s != cpol);   // RULE_02
        dup_pend_r <= !master && cpha && (sclk_s != cpol) && btype;
      end
      else if (load_p && !abort_p && dup_pend_r)
        dup_pend_r <= 1'b0;                                  // RULE_04
    end
  end

  // ----------------------------------------------------------------
  // Data buffers
  // ----------------------------------------------------------------
  logic tx_write_ok;
  assign tx_write_ok = !(guard_mode && !ste_active);         // RULE_08

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      txbuf_r     <= 8'h00;
      tx_full_r   <= 1'b0;
      last_byte_r <= 8'h00;
    end
    else
    begin
      if (load_p && !abort_p)
        last_byte_r <= load_byte;
      if (wr && paddr == ADDR_TXBUF && tx_write_ok)          // RULE_09
      begin
        txbuf_r   <= pwdata[7:0];
        tx_full_r <= 1'b1;
      end
      else if (consume_p)
        tx_full_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rxbuf_r   <= 8'h00;
      rx_full_r <= 1'b0;
    end
    else if (sif.byte_done && !rx_blocked)                   // RULE_03
    begin
      rxbuf_r   <= sif.rx_byte;
      rx_full_r <= 1'b1;
    end
    else if (rd && paddr == ADDR_RXBUF)
      rx_full_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Master clock generator
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mstate_r  <= M_IDLE;
      div_cnt_r <= 8'h00;
      sclk_r    <= 1'b0;
    end
    else if (swrst || !master)
    begin
      mstate_r  <= M_IDLE;
      div_cnt_r <= 8'h00;
      sclk_r    <= cpol;                                     // RULE_01
    end
    else
    begin
      div_cnt_r <= (div_tick || mstate_r != M_RUN) ? 8'h00
                                                   : div_cnt_r + 8'h01;
      case (mstate_r)
        M_IDLE:
        begin
          sclk_r <= cpol;
          if (!at_end && (!guard_mode || ste_active))        // RULE_07
            mstate_r <= M_RUN;
        end
        M_RUN:
        begin
          if (abort_p)
          begin
            mstate_r <= M_HOLD;                              // RULE_10
            sclk_r   <= cpol;
          end
          else if (at_end && sclk_r == cpol && !tx_full_r && !load_p)
            mstate_r <= M_IDLE;
          else if (div_tick)
            sclk_r <= ~sclk_r;
        end
        M_HOLD:
          if (ste_active)
            mstate_r <= M_RUN;                               // RULE_10
        default: mstate_r <= M_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Events, mask and interrupt
  // ----------------------------------------------------------------
  logic [ST_W-1:0] ev;
  always_comb
  begin
    ev              = '0;
    ev[ST_RX]       = sif.byte_done && !rx_blocked;
    ev[ST_TX]       = consume_p;
    ev[ST_FAULT]    = swrst_d_r && !swrst && !master && cpha
                      && (sclk_s != cpol);
    ev[ST_ABORT]    = abort_p;
    ev[ST_REFUSED]  = wr && paddr == ADDR_TXBUF && !tx_write_ok;
    ev[ST_RESEND]   = (rstate_r == R_CLR);                   // RULE_06
  end

  // Clear only what the read returned; set wins so no event is lost
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      status_r <= '0;
    else if (rd && paddr == ADDR_STATUS)
      status_r <= (status_r & ~prdata[ST_W-1:0]) | ev;
    else
      status_r <= status_r | ev;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      mask_r <= MASK_RESET;
    else if (wr && paddr == ADDR_MASK)
      mask_r <= pwdata[ST_W-1:0];
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(status_r & mask_r);
  end

  // ----------------------------------------------------------------
  // APB answer: one wait-free access phase after setup
  // ----------------------------------------------------------------
  logic        mapped;
  logic [31:0] rdata;
  always_comb
  begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    case (paddr)
      ADDR_CTRL:   rdata = {16'h0000, ctrl_r};
      ADDR_TXBUF:  rdata = {24'h00_0000, txbuf_r};
      ADDR_RXBUF:  rdata = {24'h00_0000, rxbuf_r};
      ADDR_STATUS: rdata = {26'h000_0000, status_r};
      ADDR_MASK:   rdata = {26'h000_0000, mask_r};
      ADDR_STATE:  rdata = {24'h00_0000, ste_n_s, sclk_s, mstate_r,
                            dup_pend_r, fault_r, rx_full_r, tx_full_r};
      default:     mapped = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite)
        prdata <= rdata;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_out  <= 1'b0;
      sclk_oe   <= 1'b0;
      mosi_out  <= 1'b0;
      mosi_oe   <= 1'b0;
      miso_out  <= 1'b0;
      miso_oe   <= 1'b0;
      ste_n_out <= 1'b1;
      ste_oe    <= 1'b0;
    end
    else
    begin
      sclk_out  <= sclk_r;
      sclk_oe   <= master && !swrst;
      mosi_out  <= master && sif.out_bit;
      mosi_oe   <= master && !swrst;
      miso_out  <= !master && sif.out_bit;
      miso_oe   <= !master && !swrst;
      ste_n_out <= (mstate_r != M_RUN);                      // RULE_07
      ste_oe    <= master && fourpin && ste_role;            // RULE_07
    end
  end

endmodule

// File: tb/spi_quirk_props.sv
// Port checker of the SPI quirk unit, bound to its top module
`timescale 1ns/1ps
module spi_quirk_props
  import spi_quirk_pkg::*;
(
  // Clock, reset and APB
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pin drivers
  input wire logic        sclk_out,
  input wire logic        sclk_oe,
  input wire logic        miso_oe,
  input wire logic        ste_n_out,
  input wire logic        ste_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // ------
  // Control shadow, moved only by APB writes
  // ------
  logic [7:0] ctl_r;
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      ctl_r <= CTRL_RESET[7:0];
    else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL)
      ctl_r <= pwdata[7:0];

  ready_after_setup_a:
    assert property (psel && !penable |=> pready) else $error("no pready");
  ready_single_a:
    assert property (pready |=> !pready) else $error("pready too long");
  unmapped_err_a:
    assert property (psel && !penable && paddr > ADDR_STATE |=> pslverr)
      else $error("no pslverr");
  mapped_ok_a:
    assert property (psel && !penable && paddr == ADDR_CTRL |=> !pslverr)
      else $error("spurious pslverr");
  clock_idle_a:
    assert property ((ste_n_out && $stable(ctl_r)) [*3] ##0 sclk_oe
      |-> sclk_out == ctl_r[CTL_CPOL]) else $error("clock off idle");
  reset_quiet_a:
    assert property (ctl_r[CTL_SWRST] [*2] |-> !sclk_oe && !miso_oe)
      else $error("pins driven in soft reset");
  enable_role_a:
    assert property ((!ctl_r[CTL_SWRST] && $stable(ctl_r)) [*2] |-> ste_oe
      == (ctl_r[CTL_MASTER] && ctl_r[CTL_FOURPIN] && ctl_r[CTL_STEROLE]))
      else $error("enable pin role wrong");
  master_drive_a:
    assert property ((!ctl_r[CTL_SWRST] && $stable(ctl_r)) [*2]
      |-> sclk_oe == ctl_r[CTL_MASTER]) else $error("clock drive wrong");

  cover property (pslverr);
  cover property (ste_oe && !ste_n_out);
  cover property (sclk_oe && $rose(sclk_out));
endmodule

bind spi_quirk_unit spi_quirk_props u_props (
  .sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .sclk_out, .sclk_oe, .miso_oe, .ste_n_out, .ste_oe
);

// File: tb/spi_far_master.sv
// Far-side SPI master model driving clock and data into the slave
`timescale 1ns/1ps
module spi_far_master (
  // Serial pins
  input  wire logic miso,
  output logic      sclk,
  output logic      mosi
);
  logic cpol;
  logic cpha;
  initial {cpol, cpha, sclk, mosi} = 4'h0;

  // Level may be off idle only when a test provokes the fault
  task automatic setup(input logic pol, pha, lvl);
    cpol = pol;
    cpha = pha;
    sclk = lvl;
  endtask

  // Half period 160 ns; late sampling rides out the slave's lag
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #7;
    if (!cpha)
      mosi = tx[7];
    #160;
    for (int i = 7; i >= 0; i--)
    begin
      sclk = !cpol;
      if (cpha)
        mosi = tx[i];
      #150;
      if (!cpha)
        rx[i] = miso;
      #10 sclk = cpol;
      if (!cpha && i > 0)
        mosi = tx[i-1];
      #150;
      if (cpha)
        rx[i] = miso;
      #10;
    end
    mosi = !mosi;
  endtask
endmodule

// File: tb/spi_quirk_unit_tb_top.sv
// Self-checking bench of the SPI quirk unit
`timescale 1ns/1ps
module spi_quirk_unit_tb_top;
  import spi_quirk_pkg::*;
  logic        sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, ste_n_in = 1'b0, sclk_q = 1'b0, saw = 1'b0;
  logic        pready, pslverr, irq, sclk_out, sclk_oe, mosi_out, mosi_oe;
  logic        miso_out, miso_oe, ste_n_out, ste_oe, f_sclk, f_mosi, err;
  logic [7:0]  paddr = 8'h00, rxb, mcap = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int          mismatches = 0, checks_done = 0, cycles = 0;
  wire         sclk_w = sclk_oe ? sclk_out : f_sclk;
  wire         mosi_w = mosi_oe ? mosi_out : f_mosi;
  wire         miso_w = miso_oe ? miso_out : !f_mosi;

  spi_quirk_unit u_dut (
    .sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .sclk_in(sclk_w), .sclk_out, .sclk_oe,
    .mosi_in(mosi_w), .mosi_out, .mosi_oe, .miso_in(miso_w), .miso_out,
    .miso_oe, .ste_n_in, .ste_n_out, .ste_oe
  );
  spi_far_master u_far (.miso(miso_w), .sclk(f_sclk), .mosi(f_mosi));

  always #20 sys_clk = !sys_clk;

  // Master bits at each rising serial clock; hang guard
  always @(posedge sys_clk)
  begin
    sclk_q <= sclk_out;
    if (sclk_oe && sclk_out && !sclk_q)
      mcap <= {mcap[6:0], mosi_out};
    if (ste_oe && !ste_n_out)
      saw <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      close_out();
    end
  end

  // ------
  // Tasks
  // ------
  task automatic check(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (!pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask

  // Poll the master state field until it reads s
  task automatic wait_st(input logic [1:0] s);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, ADDR_STATE, 32'h0);
      n++;
    end
    while (rd[5:4] !== s && n < 300);
    if (n >= 300)
      mismatches++;
  endtask

  initial
  begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    rdc(ADDR_CTRL, 32'hFFFF, {16'h0, CTRL_RESET});
    rdc(ADDR_MASK, 32'h3F, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    u_far.setup(1'b0, 1'b0, 1'b0);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_MASK, 32'h1);
    wr(ADDR_TXBUF, 32'h3C);
    u_far.xfer(8'hA5, rxb);
    check({24'h0, rxb}, 32'h3C);
    check({31'h0, irq}, 32'h1);
    rdc(ADDR_RXBUF, 32'hFF, 32'hA5);
    rdc(ADDR_STATUS, 32'h5, 32'h1);
    rdc(ADDR_MASK, 32'h3F, 32'h1);
    check({31'h0, irq}, 32'h0);
    wr(ADDR_MASK, 32'h0);
    wr(ADDR_CTRL, 32'h7);
    u_far.setup(1'b1, 1'b1, 1'b1);
    u_far.xfer(8'hE7, rxb);
    rdc(ADDR_STATE, 32'h2, 32'h0);
    wr(ADDR_CTRL, 32'h6);
    wr(ADDR_TXBUF, 32'h81);
    u_far.xfer(8'h5A, rxb);
    check({24'h0, rxb}, 32'h81);
    check({31'h0, irq}, 32'h0);
    rdc(ADDR_RXBUF, 32'hFF, 32'h5A);
    rdc(ADDR_STATUS, 32'h5, 32'h1);
    u_far.setup(1'b0, 1'b1, 1'b1);
    wr(ADDR_CTRL, 32'h83);
    wr(ADDR_CTRL, 32'h82);
    u_far.setup(1'b0, 1'b1, 1'b0);
    wr(ADDR_TXBUF, 32'hC3);
    u_far.xfer(8'h96, rxb);
    check({25'h0, rxb[7:1]}, 32'h43);
    rdc(ADDR_STATE, 32'h2, 32'h0);
    rdc(ADDR_STATUS, 32'h5, 32'h4);
    wr(ADDR_TXBUF, 32'h3C);
    u_far.xfer(8'h69, rxb);
    rdc(ADDR_STATUS, 32'h20, 32'h20);
    u_far.setup(1'b0, 1'b1, 1'b1);
    wr(ADDR_CTRL, 32'h43);
    wr(ADDR_CTRL, 32'h42);
    u_far.setup(1'b0, 1'b1, 1'b0);
    wr(ADDR_TXBUF, 32'h11);
    u_far.xfer(8'h22, rxb);
    check({24'h0, rxb}, 32'h11);
    u_far.xfer(8'h33, rxb);
    check({24'h0, rxb}, 32'h11);
    rdc(ADDR_RXBUF, 32'hFF, 32'h33);
    rdc(ADDR_STATUS, 32'h4, 32'h4);
    wr(ADDR_CTRL, 32'h38);
    wr(ADDR_TXBUF, 32'hA5);
    wait_st(2'h1);
    wait_st(2'h0);
    check({24'h0, mcap}, 32'hA5);
    check({31'h0, saw}, 32'h1);
    rdc(ADDR_STATUS, 32'h2, 32'h2);
    ste_n_in <= 1'b1;
    wr(ADDR_CTRL, 32'h318);
    wr(ADDR_TXBUF, 32'h55);
    rdc(ADDR_STATUS, 32'h12, 32'h10);
    ste_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rdc(ADDR_STATE, 32'h80, 32'h0);
    wr(ADDR_TXBUF, 32'h66);
    wait_st(2'h1);
    ste_n_in <= 1'b1;
    wait_st(2'h2);
    rdc(ADDR_STATUS, 32'h8, 32'h8);
    ste_n_in <= 1'b0;
    wait_st(2'h1);
    wait_st(2'h0);
    check({24'h0, mcap}, 32'h66);
    close_out();
  end
endmodule
